// ==== cmd_select_cfg.svh ====
// offsets, field positions, reset values and selector codes of the command selector
`ifndef CMD_SELECT_CFG_SVH
`define CMD_SELECT_CFG_SVH

// ------------------------
// register offsets
// ------------------------
`define OFS_FORCE_MASK 8'h13
`define OFS_FREQ_SRC 8'h14
`define OFS_OP_SRC 8'h15
`define OFS_STOP_METHOD 8'h16
`define OFS_DIR_LIMIT 8'h17
`define OFS_KEYPAD_MEM 8'h18
`define OFS_PID_TARGET 8'h30
`define OFS_LR_OPTION 8'h31
`define OFS_STATUS 8'h32

// ------------------------
// reset values
// ------------------------
`define RST_FREQ_SRC 16'h0000
`define RST_OP_SRC 16'h0000
`define RST_STOP_METHOD 16'h0000
`define RST_DIR_LIMIT 16'h0000
`define RST_KEYPAD_MEM 16'h0000
`define RST_PID_TARGET 16'h0000
`define RST_LR_OPTION 16'h0000

// ------------------------
// selector codes
// ------------------------
`define FSRC_KEYPAD 16'h0000
`define FSRC_RS485 16'h0001
`define FSRC_ANALOG 16'h0002
`define FSRC_UPDOWN 16'h0003
`define FSRC_PULSE 16'h0004
`define FSRC_NONE 16'h0006
`define FSRC_DIAL 16'h0007
`define FSRC_CARD 16'h0008
`define FSRC_PID 16'h0009
`define OSRC_KEYPAD 16'h0000
`define OSRC_TERMINAL 16'h0001
`define OSRC_RS485 16'h0002
`define OSRC_NONE 16'h0003
`define OSRC_CARD 16'h0005
`define STOP_RAMP 16'h0000
`define STOP_COAST 16'h0001
`define DIR_BOTH 16'h0000
`define DIR_NO_REVERSE 16'h0001
`define DIR_NO_FORWARD 16'h0002
`define PID_TARGET_LOCK 16'h0001
`define LR_OPT_HOA 16'h0000

// ------------------------
// field positions
// ------------------------
`define MASK_BIT_CTRL 0
`define MASK_BIT_FREQ 1
`define MASK_BIT_TORQUE 3
`define STAT_BIT_HAND 0
`define STAT_BIT_OFF 1
`define STAT_BIT_RUN 2
`define STAT_BIT_REV 3
`define STAT_BIT_JOG 4
`define STAT_BIT_OUT_EN 5

`endif

// ==== cmd_select_pkg.sv ====
// types shared by the command selector modules
package cmd_select_pkg;

  typedef enum logic [2:0] {
    MODE_AUTO = 3'b001,
    MODE_HAND = 3'b010,
    MODE_OFF = 3'b100
  } hoa_mode_t;

  typedef struct packed {
    logic [15:0] keypad;
    logic [15:0] rs485;
    logic [15:0] analog;
    logic [15:0] updown;
    logic [15:0] pulse;
    logic [15:0] dial;
    logic [15:0] card;
    logic [15:0] pid;
  } freq_sources_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic jog;
  } run_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic rd_en;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] freq;
    logic en;
  } ramp_state_t;

  typedef struct packed {
    logic [15:0] freq_src;
    logic [15:0] op_src;
    logic [15:0] stop_method;
    logic [15:0] dir_limit;
    logic [15:0] keypad_mem;
    logic [15:0] pid_target;
    logic [15:0] lr_option;
    hoa_mode_t mode;
    logic [15:0] target;
    logic run;
    logic reverse;
    logic jog;
    logic coast;
    logic trip_prev;
    logic [15:0] rd_data;
  } main_state_t;

endpackage : cmd_select_pkg

// ==== pin_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // stage one feeds stage two only
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < WIDTH; i++) begin
      st_next.s1[i] = pin_in[i];
      st_next.s2[i] = st_reg.s1[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_out = st_reg.s2;
endmodule : pin_sync

// ==== freq_ramp.sv ====
// output frequency ramp with ramp-to-stop and coast-to-stop
`timescale 1ns/10ps
module freq_ramp
  import cmd_select_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run_req,
  input wire logic coast,
  input wire logic [15:0] target_freq,
  input wire logic [15:0] step,
  input wire logic [15:0] min_freq,
  output logic [15:0] freq_out,
  output logic out_en
);
  ramp_state_t st_reg;
  ramp_state_t st_next;
  logic [16:0] up_sum;
  logic [15:0] goal;

  always_comb begin
    st_next = st_reg;
    goal = run_req ? target_freq : min_freq;
    up_sum = {1'b0, st_reg.freq} + {1'b0, step};
    if (run_req) begin
      st_next.en = 1'b1;
    end
    if (st_reg.freq < goal) begin
      st_next.freq = (up_sum > {1'b0, goal}) ? goal : up_sum[15:0];
    end else if (st_reg.freq > goal) begin
      st_next.freq = ((st_reg.freq - goal) <= step) ? goal : st_reg.freq - step;
    end
    if (!run_req) begin
      if (coast) begin
        // drop drive at once, motor spins down on its own
        st_next.freq = 16'h0000;
        st_next.en = 1'b0;
      end else if (st_reg.freq <= min_freq) begin
        st_next.freq = 16'h0000;
        st_next.en = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign freq_out = st_reg.freq;
  assign out_en = st_reg.en;
endmodule : freq_ramp

// ==== drive_command_source_select.sv ====
// frequency and operation command source selector with hand/auto switching
//
// Behaviour
// - source 0-3: keypad, RS-485, analog, up/down
// - source 4,6,7,8,9: pulse, none, dial, card, PID
// - reset comes up in auto/remote mode
// - terminal mode request beats other requests
// - writing frequency source 9 sets PID target 1
// - PID target 1 locks frequency source at 9
// - run source 0,1,2,3,5: keypad, terminal, RS-485, none, card
// - HAND_OFF_AUTO_SWITCH with 41/42 off ignores run, jog
// - HAND_OFF_AUTO_SWITCH only with terminal function or remote keypad
// - keypad run source forbids local/remote switching
// - stop method 0 ramps down then halts
// - stop method 1 cuts output, motor coasts
// - direction limit: both, no reverse, no forward
// - keypad source captures frequency on undervoltage/fault
// - mask bit 3 shows torque forced by controller
// - mask bits 0/1 show control/frequency forced
`timescale 1ns/10ps
`include "cmd_select_cfg.svh"
module drive_command_source_select
  import cmd_select_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rd_data,
  input wire freq_sources_t freq_sources,
  input wire run_cmd_t keypad_cmd,
  input wire run_cmd_t rs485_cmd,
  input wire run_cmd_t card_cmd,
  input wire logic term_run,
  input wire logic term_reverse,
  input wire logic term_jog,
  input wire logic term_hand,
  input wire logic term_auto,
  input wire logic undervoltage_event,
  input wire logic fault,
  input wire logic remote_keypad_present,
  input wire logic terminal_hoa_assigned,
  input wire logic keypad_mode_req,
  input wire logic keypad_mode_hand,
  input wire logic plc_ctrl_forced,
  input wire logic plc_freq_forced,
  input wire logic plc_torque_forced,
  input wire logic [15:0] ramp_step,
  input wire logic [15:0] minimum_output_frequency,
  output logic [15:0] freq_command_out,
  output logic output_enable,
  output logic run_out,
  output logic reverse_out,
  output logic jog_out,
  output logic hand_mode
);
  // ------------------------
  // pin synchronisers
  // ------------------------
  localparam int SYNC_W = 8;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic term_run_s;
  logic term_rev_s;
  logic term_jog_s;
  logic term_hand_s;
  logic term_auto_s;
  logic uv_s;
  logic fault_s;
  logic rkp_s;

  assign pins_raw = {remote_keypad_present, fault, undervoltage_event,
                     term_auto, term_hand, term_jog, term_reverse, term_run};

  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_in(pins_raw),
    .pin_out(pins_s)
  );

  assign term_run_s = pins_s[0];
  assign term_rev_s = pins_s[1];
  assign term_jog_s = pins_s[2];
  assign term_hand_s = pins_s[3];
  assign term_auto_s = pins_s[4];
  assign uv_s = pins_s[5];
  assign fault_s = pins_s[6];
  assign rkp_s = pins_s[7];

  // ------------------------
  // state
  // ------------------------
  main_state_t st_reg;
  main_state_t st_next;

  logic hoa_valid;
  logic switch_allowed;
  logic freq_code_ok;
  logic op_code_ok;
  logic wr_freq;
  logic wr_op;
  logic wr_stop;
  logic wr_dir;
  logic wr_pid;
  logic wr_lr;
  logic trip_now;
  logic [15:0] auto_freq;
  logic [15:0] sel_freq;
  run_cmd_t term_cmd;
  run_cmd_t auto_cmd;
  run_cmd_t sel_cmd;
  logic dir_blocked;
  logic [15:0] force_mask;
  logic [15:0] status_word;
  logic [15:0] ramp_freq;
  logic ramp_en;

  assign wr_freq = reg_wr_en && (reg_addr == `OFS_FREQ_SRC);
  assign wr_op = reg_wr_en && (reg_addr == `OFS_OP_SRC);
  assign wr_stop = reg_wr_en && (reg_addr == `OFS_STOP_METHOD);
  assign wr_dir = reg_wr_en && (reg_addr == `OFS_DIR_LIMIT);
  assign wr_pid = reg_wr_en && (reg_addr == `OFS_PID_TARGET);
  assign wr_lr = reg_wr_en && (reg_addr == `OFS_LR_OPTION);
  assign term_cmd = '{run: term_run_s, reverse: term_rev_s, jog: term_jog_s};

  // only listed codes are stored
  always_comb begin
    case (reg_wr_data)
      `FSRC_KEYPAD, `FSRC_RS485, `FSRC_ANALOG, `FSRC_UPDOWN, `FSRC_PULSE,
      `FSRC_NONE, `FSRC_DIAL, `FSRC_CARD, `FSRC_PID: begin
        freq_code_ok = 1'b1;
      end
      default: begin
        freq_code_ok = 1'b0;
      end
    endcase
    case (reg_wr_data)
      `OSRC_KEYPAD, `OSRC_TERMINAL, `OSRC_RS485, `OSRC_NONE, `OSRC_CARD: begin
        op_code_ok = 1'b1;
      end
      default: begin
        op_code_ok = 1'b0;
      end
    endcase
  end

  // ------------------------
  // source multiplexers
  // ------------------------
  always_comb begin
    case (st_reg.freq_src)
      `FSRC_KEYPAD: auto_freq = freq_sources.keypad;
      `FSRC_RS485: auto_freq = freq_sources.rs485;
      `FSRC_ANALOG: auto_freq = freq_sources.analog;
      `FSRC_UPDOWN: auto_freq = freq_sources.updown;
      `FSRC_PULSE: auto_freq = freq_sources.pulse;
      `FSRC_DIAL: auto_freq = freq_sources.dial;
      `FSRC_CARD: auto_freq = freq_sources.card;
      `FSRC_PID: auto_freq = freq_sources.pid;
      default: auto_freq = 16'h0000;
    endcase
    case (st_reg.op_src)
      `OSRC_KEYPAD: auto_cmd = keypad_cmd;
      `OSRC_TERMINAL: auto_cmd = term_cmd;
      `OSRC_RS485: auto_cmd = rs485_cmd;
      `OSRC_CARD: auto_cmd = card_cmd;
      default: auto_cmd = '0;
    endcase
    // hand mode always runs from the keypad
    case (st_reg.mode)
      MODE_HAND: begin
        sel_freq = freq_sources.keypad;
        sel_cmd = keypad_cmd;
      end
      MODE_AUTO: begin
        sel_freq = auto_freq;
        sel_cmd = auto_cmd;
      end
      default: begin
        sel_freq = 16'h0000;
        sel_cmd = '0;
      end
    endcase
  end

  // reverse blocked on 1, forward on 2
  always_comb begin
    case (st_reg.dir_limit)
      `DIR_NO_REVERSE: dir_blocked = sel_cmd.reverse;
      `DIR_NO_FORWARD: dir_blocked = !sel_cmd.reverse;
      default: dir_blocked = 1'b0;
    endcase
  end

  // ------------------------
  // hand/off/auto control
  // ------------------------
  assign hoa_valid = terminal_hoa_assigned || rkp_s;
  assign switch_allowed = hoa_valid && (st_reg.op_src != `OSRC_KEYPAD);
  assign trip_now = uv_s || fault_s;

  assign force_mask = {12'h000, plc_torque_forced, 1'b0, plc_freq_forced, plc_ctrl_forced};

  always_comb begin
    status_word = 16'h0000;
    status_word[`STAT_BIT_HAND] = (st_reg.mode == MODE_HAND);
    status_word[`STAT_BIT_OFF] = (st_reg.mode == MODE_OFF);
    status_word[`STAT_BIT_RUN] = st_reg.run;
    status_word[`STAT_BIT_REV] = st_reg.reverse;
    status_word[`STAT_BIT_JOG] = st_reg.jog;
    status_word[`STAT_BIT_OUT_EN] = ramp_en;
  end

  // ------------------------
  // next state
  // ------------------------
  always_comb begin
    st_next = st_reg;

    if (wr_freq && freq_code_ok) begin
      // locked at PID while the PID target points at it
      if (!(st_reg.pid_target == `PID_TARGET_LOCK && reg_wr_data != `FSRC_PID)) begin
        st_next.freq_src = reg_wr_data;
        if (reg_wr_data == `FSRC_PID) begin
          st_next.pid_target = `PID_TARGET_LOCK;
        end
      end
    end
    if (wr_pid) begin
      st_next.pid_target = reg_wr_data;
      if (reg_wr_data == `PID_TARGET_LOCK) begin
        st_next.freq_src = `FSRC_PID;
      end
    end
    if (wr_op && op_code_ok) begin
      st_next.op_src = reg_wr_data;
    end
    if (wr_stop && reg_wr_data <= `STOP_COAST) begin
      st_next.stop_method = reg_wr_data;
    end
    if (wr_dir && reg_wr_data <= `DIR_NO_FORWARD) begin
      st_next.dir_limit = reg_wr_data;
    end
    if (wr_lr) begin
      st_next.lr_option = reg_wr_data;
    end

    // mode: the terminal outranks the keypad request
    case (st_reg.mode)
      MODE_AUTO, MODE_HAND, MODE_OFF: begin
        if (!switch_allowed) begin
          st_next.mode = MODE_AUTO;
        end else if (terminal_hoa_assigned && term_hand_s) begin
          st_next.mode = MODE_HAND;
        end else if (terminal_hoa_assigned && term_auto_s) begin
          st_next.mode = MODE_AUTO;
        end else if (terminal_hoa_assigned && st_reg.lr_option == `LR_OPT_HOA) begin
          st_next.mode = MODE_OFF;
        end else if (keypad_mode_req) begin
          st_next.mode = keypad_mode_hand ? MODE_HAND : MODE_AUTO;
        end
      end
      default: begin
        st_next.mode = MODE_AUTO;
      end
    endcase

    // command outputs, held at the last direction while ramping down
    st_next.target = sel_freq;
    st_next.run = sel_cmd.run && !dir_blocked;
    st_next.jog = sel_cmd.jog && !dir_blocked && (st_reg.mode != MODE_OFF);
    if (sel_cmd.run || sel_cmd.jog) begin
      st_next.reverse = sel_cmd.reverse;
    end
    st_next.coast = (st_reg.stop_method == `STOP_COAST);

    // capture on the rising edge of a trip while the keypad is the source
    st_next.trip_prev = trip_now;
    if (trip_now && !st_reg.trip_prev && st_reg.freq_src == `FSRC_KEYPAD) begin
      st_next.keypad_mem = freq_sources.keypad;
    end

    st_next.rd_data = 16'h0000;
    if (reg_rd_en) begin
      case (reg_addr)
        `OFS_FORCE_MASK: st_next.rd_data = force_mask;
        `OFS_FREQ_SRC: st_next.rd_data = st_reg.freq_src;
        `OFS_OP_SRC: st_next.rd_data = st_reg.op_src;
        `OFS_STOP_METHOD: st_next.rd_data = st_reg.stop_method;
        `OFS_DIR_LIMIT: st_next.rd_data = st_reg.dir_limit;
        `OFS_KEYPAD_MEM: st_next.rd_data = st_reg.keypad_mem;
        `OFS_PID_TARGET: st_next.rd_data = st_reg.pid_target;
        `OFS_LR_OPTION: st_next.rd_data = st_reg.lr_option;
        `OFS_STATUS: st_next.rd_data = status_word;
        default: st_next.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg.freq_src <= `RST_FREQ_SRC;
      st_reg.op_src <= `RST_OP_SRC;
      st_reg.stop_method <= `RST_STOP_METHOD;
      st_reg.dir_limit <= `RST_DIR_LIMIT;
      st_reg.keypad_mem <= `RST_KEYPAD_MEM;
      st_reg.pid_target <= `RST_PID_TARGET;
      st_reg.lr_option <= `RST_LR_OPTION;
      st_reg.mode <= MODE_AUTO;
      st_reg.target <= 16'h0000;
      st_reg.run <= 1'b0;
      st_reg.reverse <= 1'b0;
      st_reg.jog <= 1'b0;
      st_reg.coast <= 1'b0;
      st_reg.trip_prev <= 1'b0;
      st_reg.rd_data <= 16'h0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------
  // output ramp
  // ------------------------
  freq_ramp u_freq_ramp (
    .core_clk(core_clk),
    .rstn(rstn),
    .run_req(st_reg.run || st_reg.jog),
    .coast(st_reg.coast),
    .target_freq(st_reg.target),
    .step(ramp_step),
    .min_freq(minimum_output_frequency),
    .freq_out(ramp_freq),
    .out_en(ramp_en)
  );

  assign reg_rd_data = st_reg.rd_data;
  assign freq_command_out = ramp_freq;
  assign output_enable = ramp_en;
  assign run_out = st_reg.run;
  assign reverse_out = st_reg.reverse;
  assign jog_out = st_reg.jog;
  assign hand_mode = st_reg.mode[1];
endmodule : drive_command_source_select

// ==== cmd_select_chk.sv ====
// concurrent checks on the command selector ports
`timescale 1ns/10ps
module cmd_select_chk (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rd_data,
  input wire logic remote_keypad_present,
  input wire logic terminal_hoa_assigned,
  input wire logic plc_ctrl_forced,
  input wire logic plc_freq_forced,
  input wire logic plc_torque_forced,
  input wire logic [15:0] ramp_step,
  input wire logic [15:0] minimum_output_frequency,
  input wire logic [15:0] freq_command_out,
  input wire logic output_enable,
  input wire logic run_out,
  input wire logic reverse_out,
  input wire logic jog_out,
  input wire logic hand_mode
);
  // ------------------------------------------------------------
  // shadows of accepted writes; refused codes never land
  // ------------------------------------------------------------
  logic [15:0] op_reg, stop_reg, dir_reg;
  logic [16:0] floor_sum;
  assign floor_sum = {1'b0, minimum_output_frequency} + {1'b0, ramp_step};
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      op_reg <= 16'h0000;
      stop_reg <= 16'h0000;
      dir_reg <= 16'h0000;
    end else if (reg_wr_en) begin
      if (reg_addr == 8'h15 && reg_wr_data != 16'h0004 && reg_wr_data <= 16'h0005)
        op_reg <= reg_wr_data;
      if (reg_addr == 8'h16 && reg_wr_data <= 16'h0001)
        stop_reg <= reg_wr_data;
      if (reg_addr == 8'h17 && reg_wr_data <= 16'h0002)
        dir_reg <= reg_wr_data;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  property p_reset_auto;
    $rose(rstn) |-> !hand_mode && !run_out && !output_enable;
  endproperty
  a_reset_auto: assert property (p_reset_auto) else $error("not idle after reset");
  property p_mask;
    reg_rd_en && reg_addr == 8'h13 |=> reg_rd_data[3:0] ==
      {$past(plc_torque_forced), 1'b0, $past(plc_freq_forced), $past(plc_ctrl_forced)};
  endproperty
  a_mask: assert property (p_mask) else $error("force mask wrong");
  property p_coast;
    stop_reg == 16'h0001 && $fell(run_out) && !jog_out |=> !output_enable &&
      freq_command_out == 16'h0000;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop kept output");
  property p_ramp_step;
    stop_reg == 16'h0000 && output_enable && !run_out && !jog_out &&
      {1'b0, freq_command_out} > floor_sum ##1 !run_out && !jog_out
      |-> freq_command_out == $past(freq_command_out) - $past(ramp_step);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");
  property p_ramp_halt;
    stop_reg == 16'h0000 && $fell(run_out) && !jog_out |-> ##[1:600] !output_enable;
  endproperty
  a_ramp_halt: assert property (p_ramp_halt) else $error("ramp never halted");
  property p_dir;
    dir_reg == $past(dir_reg) |-> !((run_out || jog_out) &&
      (dir_reg == 16'h0001 && reverse_out || dir_reg == 16'h0002 && !reverse_out));
  endproperty
  a_dir: assert property (p_dir) else $error("blocked direction ran");
  property p_keypad_auto;
    op_reg == 16'h0000 && $past(op_reg) == 16'h0000 |-> !hand_mode;
  endproperty
  a_keypad_auto: assert property (p_keypad_auto) else $error("hand with keypad source");
  property p_hoa_gate;
    (!terminal_hoa_assigned && !remote_keypad_present) [*5] |-> !hand_mode;
  endproperty
  a_hoa_gate: assert property (p_hoa_gate) else $error("hand without switch means");
  c_ramp: cover property (stop_reg == 16'h0000 && $fell(run_out));
  c_hand: cover property ($rose(hand_mode));
  c_mask: cover property (reg_rd_en && reg_addr == 8'h13);
endmodule : cmd_select_chk

// ==== host_model.sv ====
// keypad, terminal and serial host stand-in on the selector's far side
`timescale 1ns/10ps
module host_model
  import cmd_select_pkg::*;
(
  input wire logic [3:0] run_sel,
  input wire logic rev,
  input wire logic jog,
  input wire logic [15:0] kp_freq,
  output freq_sources_t freq_sources,
  output run_cmd_t keypad_cmd,
  output run_cmd_t rs485_cmd,
  output run_cmd_t card_cmd,
  output logic term_run,
  output logic term_reverse,
  output logic term_jog
);
  // distinct value per source so a wrong route cannot hide
  assign freq_sources = {kp_freq, 112'h0202_0303_0404_0505_0707_0808_0909};
  assign keypad_cmd = {run_sel[0], rev, jog};
  assign rs485_cmd = {run_sel[2], rev, jog};
  assign card_cmd = {run_sel[3], rev, jog};
  assign term_run = run_sel[1];
  assign term_reverse = rev;
  assign term_jog = jog;
endmodule : host_model

// ==== drive_command_source_select_tb.sv ====
// self-checking bench for the command source selector
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); \
  end \
end
module drive_command_source_select_tb;
  import cmd_select_pkg::*;
  logic core_clk, rstn, reg_wr_en, reg_rd_en, rev, jog, term_hand, term_auto, fault;
  logic undervoltage_event, remote_keypad_present, terminal_hoa_assigned, keypad_mode_req;
  logic keypad_mode_hand, plc_ctrl_forced, plc_freq_forced, plc_torque_forced;
  logic output_enable, run_out, reverse_out, jog_out, hand_mode, term_run, term_reverse, term_jog;
  logic [7:0] reg_addr;
  logic [3:0] run_sel;
  logic [15:0] reg_wr_data, reg_rd_data, ramp_step, minimum_output_frequency, kp_freq, v;
  logic [15:0] freq_command_out;
  freq_sources_t freq_sources;
  run_cmd_t keypad_cmd, rs485_cmd, card_cmd;
  int comparisons, fail_count, n;
  // ------------------------------------------------------------
  // rows: written code, readback, expected output
  // ------------------------------------------------------------
  logic [47:0] frows [10] = '{48'h0000_0000_0101, 48'h0001_0001_0202, 48'h0002_0002_0303,
    48'h0003_0003_0404, 48'h0004_0004_0505, 48'h0007_0007_0707, 48'h0008_0008_0808,
    48'h0006_0006_0000, 48'h0005_0006_0000, 48'h000a_0006_0000};
  // last byte: which source carries run (keypad, terminal, serial, card)
  logic [39:0] orows [6] = '{40'h0001_0001_02, 40'h0002_0002_04, 40'h0005_0005_08,
    40'h0003_0003_00, 40'h0004_0003_00, 40'h0000_0000_01};
  host_model host_u (.run_sel, .rev, .jog, .kp_freq, .freq_sources, .keypad_cmd, .rs485_cmd,
    .card_cmd, .term_run, .term_reverse, .term_jog);
  drive_command_source_select dut_u (.core_clk, .rstn, .reg_addr, .reg_wr_data, .reg_wr_en,
    .reg_rd_en, .reg_rd_data, .freq_sources, .keypad_cmd, .rs485_cmd, .card_cmd, .term_run,
    .term_reverse, .term_jog, .term_hand, .term_auto, .undervoltage_event, .fault,
    .remote_keypad_present, .terminal_hoa_assigned, .keypad_mode_req, .keypad_mode_hand,
    .plc_ctrl_forced, .plc_freq_forced, .plc_torque_forced, .ramp_step,
    .minimum_output_frequency, .freq_command_out, .output_enable, .run_out, .reverse_out,
    .jog_out, .hand_mode);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // tasks leave 1 ns after an edge so outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    cyc(1);
    reg_wr_en <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    cyc(1);
    reg_rd_en <= 1'b0;
    d = reg_rd_data;
    cyc(1);
  endtask : rd
  task results;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // whole run is well under a thousand cycles
  initial begin
    #20_000;
    fail_count++;
    results();
  end
  initial begin
    {rstn, reg_wr_en, reg_rd_en, rev, jog, term_hand, term_auto, fault} = '0;
    {undervoltage_event, remote_keypad_present, terminal_hoa_assigned} = '0;
    {keypad_mode_req, keypad_mode_hand, plc_ctrl_forced, plc_freq_forced} = '0;
    plc_torque_forced = 1'b0;
    {reg_addr, reg_wr_data, minimum_output_frequency} = '0;
    ramp_step = 16'h1000;
    kp_freq = 16'h0101;
    run_sel = 4'b0001;
    cyc(10);
    rstn <= 1'b1;
    cyc(1);
    `CHK(hand_mode, 1'b0)
    for (int a = 8'h13; a < 8'h19; a++) begin
      rd(a[7:0], v);
      `CHK(v, 16'h0000)
    end
    wr(8'h18, 16'h1234);
    rd(8'h18, v);
    `CHK(v, 16'h0000)
    foreach (frows[i]) begin
      wr(8'h14, frows[i][47:32]);
      cyc(4);
      rd(8'h14, v);
      `CHK(v, frows[i][31:16])
      `CHK(freq_command_out, frows[i][15:0])
    end
    wr(8'h14, 16'h0009);
    rd(8'h30, v);
    `CHK(v, 16'h0001)
    wr(8'h14, 16'h0002);
    rd(8'h14, v);
    `CHK(v, 16'h0009)
    `CHK(freq_command_out, 16'h0909)
    wr(8'h30, 16'h0000);
    wr(8'h14, 16'h0000);
    rd(8'h14, v);
    `CHK(v, 16'h0000)
    foreach (orows[i]) begin
      wr(8'h15, orows[i][39:24]);
      run_sel <= ~orows[i][3:0];
      cyc(6);
      `CHK(run_out, 1'b0)
      run_sel <= orows[i][3:0];
      cyc(6);
      `CHK(run_out, |orows[i][3:0])
      rd(8'h15, v);
      `CHK(v, orows[i][23:8])
    end
    kp_freq <= 16'h0800;
    ramp_step <= 16'h0100;
    minimum_output_frequency <= 16'h0100;
    cyc(12);
    `CHK(freq_command_out, 16'h0800)
    run_sel <= 4'b0000;
    cyc(3);
    `CHK(output_enable, 1'b1)
    `CHK(freq_command_out < 16'h0800, 1'b1)
    n = 0;
    while (output_enable === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    `CHK(freq_command_out, 16'h0000)
    wr(8'h16, 16'h0001);
    run_sel <= 4'b0001;
    cyc(12);
    run_sel <= 4'b0000;
    cyc(2);
    `CHK(output_enable, 1'b0)
    `CHK(freq_command_out, 16'h0000)
    wr(8'h16, 16'h0002);
    rd(8'h16, v);
    `CHK(v, 16'h0001)
    run_sel <= 4'b0001;
    for (int d = 0; d < 3; d++) begin
      wr(8'h17, d[15:0]);
      for (int r = 0; r < 2; r++) begin
        rev <= r[0];
        cyc(5);
        `CHK(run_out, !((d == 1 && r == 1) || (d == 2 && r == 0)))
        `CHK(reverse_out, r[0])
      end
    end
    wr(8'h17, 16'h0000);
    rev <= 1'b0;
    fault <= 1'b1;
    cyc(5);
    fault <= 1'b0;
    rd(8'h18, v);
    `CHK(v, 16'h0800)
    wr(8'h14, 16'h0001);
    kp_freq <= 16'h0300;
    undervoltage_event <= 1'b1;
    cyc(5);
    undervoltage_event <= 1'b0;
    rd(8'h18, v);
    `CHK(v, 16'h0800)
    {plc_torque_forced, plc_freq_forced} <= 2'b11;
    cyc(1);
    rd(8'h13, v);
    `CHK(v, 16'h000a)
    {plc_torque_forced, plc_freq_forced, plc_ctrl_forced} <= 3'b001;
    cyc(1);
    rd(8'h13, v);
    `CHK(v, 16'h0001)
    terminal_hoa_assigned <= 1'b1;
    term_hand <= 1'b1;
    cyc(6);
    `CHK(hand_mode, 1'b0)
    wr(8'h15, 16'h0001);
    run_sel <= 4'b0010;
    term_hand <= 1'b0;
    jog <= 1'b1;
    cyc(6);
    `CHK(run_out, 1'b0)
    `CHK(jog_out, 1'b0)
    jog <= 1'b0;
    term_auto <= 1'b1;
    cyc(6);
    `CHK(run_out, 1'b1)
    keypad_mode_hand <= 1'b1;
    keypad_mode_req <= 1'b1;
    cyc(1);
    keypad_mode_req <= 1'b0;
    cyc(4);
    `CHK(hand_mode, 1'b0)
    term_auto <= 1'b0;
    term_hand <= 1'b1;
    cyc(6);
    `CHK(hand_mode, 1'b1)
    rd(8'h32, v);
    `CHK(v[0], 1'b1)
    terminal_hoa_assigned <= 1'b0;
    cyc(6);
    `CHK(hand_mode, 1'b0)
    remote_keypad_present <= 1'b1;
    cyc(3);
    keypad_mode_req <= 1'b1;
    cyc(1);
    keypad_mode_req <= 1'b0;
    cyc(3);
    `CHK(hand_mode, 1'b1)
    rstn <= 1'b0;
    cyc(10);
    rstn <= 1'b1;
    cyc(1);
    `CHK(hand_mode, 1'b0)
    results();
  end
endmodule : drive_command_source_select_tb
bind drive_command_source_select cmd_select_chk chk_u (.core_clk, .rstn, .reg_addr,
  .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data, .remote_keypad_present,
  .terminal_hoa_assigned, .plc_ctrl_forced, .plc_freq_forced, .plc_torque_forced, .ramp_step,
  .minimum_output_frequency, .freq_command_out, .output_enable, .run_out, .reverse_out,
  .jog_out, .hand_mode);
